// ==== common/ddrm_pkg.sv ====
// Shared constants, types and pin bundle of the separate-I/O DDR memory port.
// Assumes a 100 MHz system clock that oversamples every link pin.
package ddrm_pkg;

	// Data path and array geometry
	localparam int DATA_W    = 18;
	localparam int BANK_W    = 3;
	localparam int NUM_BANKS = 8;
	localparam int COL_W     = 6;
	localparam int ROW_W     = 4;
	localparam int BEAT_W    = 4;
	localparam int REF_W     = 4;

	// Mode register burst-length field, in the low address bits
	localparam int         MR_BL_LSB = 0;
	localparam logic [1:0] MR_BL_2   = 2'h0;
	localparam logic [1:0] MR_BL_4   = 2'h1;
	localparam logic [1:0] MR_BL_8   = 2'h2;

	// Burst lengths as word counts
	localparam logic [BEAT_W-1:0] BL_2   = 4'h2;
	localparam logic [BEAT_W-1:0] BL_4   = 4'h4;
	localparam logic [BEAT_W-1:0] BL_8   = 4'h8;
	localparam logic [BEAT_W-1:0] BL_RST = BL_2;

	// Timing: refresh occupancy is a least time, rounded up
	localparam int CLK_MHZ      = 100;
	localparam int T_REF_NS     = 20;
	localparam int REF_CYC_RAW  = (T_REF_NS * CLK_MHZ + 999) / 1000;
	localparam int REF_CYC      = (REF_CYC_RAW < 1) ? 1 : REF_CYC_RAW;
	localparam int T_RD_HALF_NS = 40;
	localparam int RD_HALF_RAW  = (T_RD_HALF_NS * CLK_MHZ) / 1000;
	localparam int RD_HALF_CYC  = (RD_HALF_RAW < 1) ? 1 : RD_HALF_RAW;

	// Decoded commands
	typedef enum logic [2:0] {
		CMD_NOP   = 3'h0,
		CMD_READ  = 3'h1,
		CMD_WRITE = 3'h2,
		CMD_AREF  = 3'h3,
		CMD_MRS   = 3'h4
	} ddrm_cmd_t;

	// All sampled link pins travel together through the synchroniser
	typedef struct packed {
		logic              cmd_clk_p;
		logic              cmd_clk_n;
		logic              cs_n;
		logic              we_n;
		logic              ref_n;
		logic [BANK_W-1:0] bank;
		logic [COL_W-1:0]  addr;
		logic              wr_data_clk_p;
		logic              wr_data_clk_n;
		logic [DATA_W-1:0] wr_data;
		logic              wr_mask;
	} ddrm_pins_t;

	// Deselected and idle, so reset never looks like a command
	localparam ddrm_pins_t PINS_RST = '{cs_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, default: '0};

endpackage

// ==== core/ddrm_buf.sv ====
// Small FIFO with valid/ready on both sides, honest full and empty.
// Assumes DEPTH is a power of two and both sides share one clock.
`timescale 1ns/1ns
`default_nettype none
module ddrm_buf #(
	parameter int W     = 18,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [W-1:0] store [DEPTH];
	logic [AW:0]  wp;
	logic [AW:0]  rp;
	logic [AW:0]  next_wp;
	logic [AW:0]  next_rp;

	// Occupancy flags from the pointer distance
	assign in_ready  = (AW+1)'(wp - rp) != FULL_CNT;
	assign out_valid = wp != rp;
	assign out_data  = store[rp[AW-1:0]];

	// Pointer advance
	always_comb begin
		next_wp = wp;
		next_rp = rp;
		if (in_valid && in_ready)
			next_wp = (AW+1)'(wp + 1'b1);
		if (out_valid && out_ready)
			next_rp = (AW+1)'(rp + 1'b1);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp <= '0;
			rp <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
		end
	end

	// Storage has no reset; only valid entries are ever read
	always_ff @(posedge clk) begin
		if (in_valid && in_ready)
			store[wp[AW-1:0]] <= in_data;
	end
endmodule
`default_nettype wire

// ==== core/ddrm_port.sv ====
// Device side of a separate-I/O DDR burst memory: command decode, bank array,
// write capture on both data-clock edges, read launch on a free-running clock.
// Assumes all link pins are asynchronous to clk and far slower than it.
//
// Behaviour
// [R1] Two data words move per input clock cycle, one per half cycle, each way.
// [R2] Read data leaves only on the read pins and write data enters only on the write pins.
// [R3] Read data is launched aligned to a free-running output data clock.
// [R4] Commands, addresses and controls are taken on each rising command clock edge.
// [R5] Write data is captured on both rising and falling data clock edges.
// [R6] Every access is a burst of 2, 4 or 8 words as programmed by mode register set.
// [R7] The array has eight independent banks picked by the bank address pins.
// [R8] Refresh is per bank and the row to refresh comes from an internal counter.
// [R9] Commands are taken only while chip select is low; running work goes on.
// [R10] A write word whose mask is sampled high is discarded.
// [R11] The controller sends each write burst on back-to-back data clock edges.
`timescale 1ns/1ns
`default_nettype none
module ddrm_port #(
	parameter int BUF_DEPTH = 2
) (
	// System
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	// Command pins
	input  wire logic                           cmd_clk_p,
	input  wire logic                           cmd_clk_n,
	input  wire logic                           cs_n,
	input  wire logic                           we_n,
	input  wire logic                           ref_n,
	input  wire logic [ddrm_pkg::BANK_W-1:0]    bank_addr,
	input  wire logic [ddrm_pkg::COL_W-1:0]     addr,
	// Write port
	input  wire logic                           wr_data_clk_p,
	input  wire logic                           wr_data_clk_n,
	input  wire logic [ddrm_pkg::DATA_W-1:0]    wr_data,
	input  wire logic                           wr_mask,
	// Read port
	output logic                                rd_data_clk_p,
	output logic                                rd_data_clk_n,
	output logic [ddrm_pkg::DATA_W-1:0]         rd_data,
	output logic                                rd_valid,
	// Status
	output logic [ddrm_pkg::BEAT_W-1:0]         burst_len,
	output logic                                ref_done,
	output logic [ddrm_pkg::ROW_W-1:0]          refresh_row
);
	localparam int IDX_W = ddrm_pkg::BANK_W + ddrm_pkg::COL_W;
	localparam logic [ddrm_pkg::REF_W-1:0] REF_LOAD = ddrm_pkg::REF_W'(ddrm_pkg::REF_CYC);
	localparam logic [2:0] HALF_LAST = 3'(ddrm_pkg::RD_HALF_CYC - 1);

	ddrm_pkg::ddrm_pins_t pins_in;
	ddrm_pkg::ddrm_pins_t sync1;
	ddrm_pkg::ddrm_pins_t sync2;
	logic                 cclk_prev;
	logic                 dclk_prev;
	logic                 cclk;
	logic                 dclk;
	logic                 cclk_rise;
	logic                 dclk_edge;
	ddrm_pkg::ddrm_cmd_t  cmd;

	// Control state and next values
	logic [ddrm_pkg::BEAT_W-1:0] next_burst_len;
	logic                        wr_act, next_wr_act;
	logic [ddrm_pkg::BANK_W-1:0] wr_bank, next_wr_bank;
	logic [ddrm_pkg::COL_W-1:0]  wr_col, next_wr_col;
	logic [ddrm_pkg::BEAT_W-1:0] wr_beat, next_wr_beat;
	logic [ddrm_pkg::BEAT_W-1:0] wr_bl, next_wr_bl;
	logic                        rd_act, next_rd_act;
	logic [ddrm_pkg::BANK_W-1:0] rd_bank, next_rd_bank;
	logic [ddrm_pkg::COL_W-1:0]  rd_col, next_rd_col;
	logic [ddrm_pkg::BEAT_W-1:0] rd_beat, next_rd_beat;
	logic [ddrm_pkg::BEAT_W-1:0] rd_bl, next_rd_bl;
	logic [ddrm_pkg::REF_W-1:0]  busy [ddrm_pkg::NUM_BANKS];
	logic [ddrm_pkg::REF_W-1:0]  next_busy [ddrm_pkg::NUM_BANKS];
	logic [ddrm_pkg::ROW_W-1:0]  row_cnt [ddrm_pkg::NUM_BANKS];
	logic [ddrm_pkg::ROW_W-1:0]  next_row_cnt [ddrm_pkg::NUM_BANKS];
	logic                        next_ref_done;
	logic [ddrm_pkg::ROW_W-1:0]  next_refresh_row;
	logic                        bank_free;
	logic                        rd_start;

	// Array and data path
	logic [ddrm_pkg::DATA_W-1:0] mem [ddrm_pkg::NUM_BANKS << ddrm_pkg::COL_W];
	logic [IDX_W-1:0]            widx;
	logic [IDX_W-1:0]            ridx;
	logic                        mem_we;
	logic                        buf_ready;
	logic                        push;
	logic                        buf_valid;
	logic [ddrm_pkg::DATA_W-1:0] buf_data;

	// Read clock divider and launch registers
	logic [2:0]                  div_cnt, next_div_cnt;
	logic                        rd_clk, next_rd_clk;
	logic [ddrm_pkg::DATA_W-1:0] next_rd_data;
	logic                        next_rd_valid;
	logic                        tick;

	// Every pin passes two flops before any logic sees it
	assign pins_in = '{cmd_clk_p, cmd_clk_n, cs_n, we_n, ref_n, bank_addr, addr,
		wr_data_clk_p, wr_data_clk_n, wr_data, wr_mask};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1     <= ddrm_pkg::PINS_RST;
			sync2     <= ddrm_pkg::PINS_RST;
			cclk_prev <= 1'b0;
			dclk_prev <= 1'b0;
		end else begin
			sync1     <= pins_in;
			sync2     <= sync1;
			cclk_prev <= cclk;
			dclk_prev <= dclk;
		end
	end

	// Differential pair counts as high only when the pair agrees
	assign cclk      = sync2.cmd_clk_p & ~sync2.cmd_clk_n;
	assign dclk      = sync2.wr_data_clk_p & ~sync2.wr_data_clk_n;
	assign cclk_rise = cclk & ~cclk_prev;           // see [R4]
	assign dclk_edge = dclk ^ dclk_prev;            // see [R5]

	// Command decoder, gated by chip select
	always_comb begin
		cmd = ddrm_pkg::CMD_NOP;
		if (cclk_rise && !sync2.cs_n) begin         // see [R4] see [R9]
			case ({sync2.we_n, sync2.ref_n})
				2'b11: cmd = ddrm_pkg::CMD_READ;
				2'b01: cmd = ddrm_pkg::CMD_WRITE;
				2'b10: cmd = ddrm_pkg::CMD_AREF;
				default: cmd = ddrm_pkg::CMD_MRS;
			endcase
		end
	end

	// A bank under refresh refuses new work until its timer runs out
	assign bank_free = busy[sync2.bank] == '0;     // see [R7]

	// Command engine: mode, write burst, read burst, per-bank refresh
	always_comb begin
		next_burst_len   = burst_len;
		next_wr_act      = wr_act;
		next_wr_bank     = wr_bank;
		next_wr_col      = wr_col;
		next_wr_beat     = wr_beat;
		next_wr_bl       = wr_bl;
		next_rd_act      = rd_act;
		next_rd_bank     = rd_bank;
		next_rd_col      = rd_col;
		next_rd_beat     = rd_beat;
		next_rd_bl       = rd_bl;
		next_ref_done    = 1'b0;
		next_refresh_row = refresh_row;
		rd_start         = 1'b0;
		for (int b = 0; b < ddrm_pkg::NUM_BANKS; b++) begin
			next_busy[b]    = (busy[b] != '0) ? ddrm_pkg::REF_W'(busy[b] - 1'b1) : busy[b];
			next_row_cnt[b] = row_cnt[b];
		end
		// Write beats count on either data clock edge
		if (wr_act && dclk_edge) begin              // see [R1] see [R5]
			next_wr_beat = ddrm_pkg::BEAT_W'(wr_beat + 1'b1);
			if (wr_beat == ddrm_pkg::BEAT_W'(wr_bl - 1'b1))
				next_wr_act = 1'b0;                 // see [R6]
		end
		// Read beats advance only while the buffer takes them
		if (push) begin
			next_rd_beat = ddrm_pkg::BEAT_W'(rd_beat + 1'b1);
			if (rd_beat == ddrm_pkg::BEAT_W'(rd_bl - 1'b1))
				next_rd_act = 1'b0;                 // see [R6]
		end
		case (cmd)
			ddrm_pkg::CMD_MRS: begin
				case (sync2.addr[ddrm_pkg::MR_BL_LSB +: 2])   // see [R6]
					ddrm_pkg::MR_BL_2: next_burst_len = ddrm_pkg::BL_2;
					ddrm_pkg::MR_BL_4: next_burst_len = ddrm_pkg::BL_4;
					ddrm_pkg::MR_BL_8: next_burst_len = ddrm_pkg::BL_8;
					default: next_burst_len = burst_len;  // Reserved code keeps the old length
				endcase
			end
			ddrm_pkg::CMD_WRITE: begin
				if (!wr_act && bank_free) begin
					next_wr_act  = 1'b1;
					next_wr_bank = sync2.bank;      // see [R7]
					next_wr_col  = sync2.addr;
					next_wr_beat = '0;
					next_wr_bl   = burst_len;
				end
			end
			ddrm_pkg::CMD_READ: begin
				if (!rd_act && bank_free) begin
					rd_start     = 1'b1;
					next_rd_act  = 1'b1;
					next_rd_bank = sync2.bank;      // see [R7]
					next_rd_col  = sync2.addr;
					next_rd_beat = '0;
					next_rd_bl   = burst_len;
				end
			end
			ddrm_pkg::CMD_AREF: begin
				// Row comes from the bank's own counter, not the pins
				if (bank_free) begin                // see [R8]
					next_busy[sync2.bank]    = REF_LOAD;
					next_row_cnt[sync2.bank] = ddrm_pkg::ROW_W'(row_cnt[sync2.bank] + 1'b1);
					next_refresh_row         = row_cnt[sync2.bank];
					next_ref_done            = 1'b1;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			burst_len   <= ddrm_pkg::BL_RST;
			wr_act      <= 1'b0;
			wr_bank     <= '0;
			wr_col      <= '0;
			wr_beat     <= '0;
			wr_bl       <= ddrm_pkg::BL_RST;
			rd_act      <= 1'b0;
			rd_bank     <= '0;
			rd_col      <= '0;
			rd_beat     <= '0;
			rd_bl       <= ddrm_pkg::BL_RST;
			ref_done    <= 1'b0;
			refresh_row <= '0;
			for (int b = 0; b < ddrm_pkg::NUM_BANKS; b++) begin
				busy[b]    <= '0;
				row_cnt[b] <= '0;
			end
		end else begin
			burst_len   <= next_burst_len;
			wr_act      <= next_wr_act;
			wr_bank     <= next_wr_bank;
			wr_col      <= next_wr_col;
			wr_beat     <= next_wr_beat;
			wr_bl       <= next_wr_bl;
			rd_act      <= next_rd_act;
			rd_bank     <= next_rd_bank;
			rd_col      <= next_rd_col;
			rd_beat     <= next_rd_beat;
			rd_bl       <= next_rd_bl;
			ref_done    <= next_ref_done;
			refresh_row <= next_refresh_row;
			busy        <= next_busy;
			row_cnt     <= next_row_cnt;
		end
	end

	// Burst addresses step from the start column and wrap inside the bank
	assign widx   = {wr_bank, ddrm_pkg::COL_W'(wr_col + ddrm_pkg::COL_W'(wr_beat))};
	assign ridx   = {rd_bank, ddrm_pkg::COL_W'(rd_col + ddrm_pkg::COL_W'(rd_beat))};
	assign mem_we = wr_act & dclk_edge & ~sync2.wr_mask;   // see [R10] see [R2]
	assign push   = rd_act & buf_ready;

	// Array write from the write pins only
	always_ff @(posedge clk) begin
		if (mem_we)
			mem[widx] <= sync2.wr_data;
	end

	// Buffer lets the read engine stall while the launch side waits for an edge
	ddrm_buf #(
		.W     (ddrm_pkg::DATA_W),
		.DEPTH (BUF_DEPTH)
	) u_rd_buf (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (rd_act),
		.in_ready  (buf_ready),
		.in_data   (mem[ridx]),
		.out_valid (buf_valid),
		.out_ready (tick),
		.out_data  (buf_data)
	);

	// Free-running read clock; each toggle launches one word while the buffer holds one
	assign tick = div_cnt == HALF_LAST;

	always_comb begin
		next_div_cnt  = tick ? '0 : 3'(div_cnt + 1'b1);
		next_rd_clk   = tick ? ~rd_clk : rd_clk;    // see [R3]
		next_rd_data  = rd_data;
		next_rd_valid = rd_valid;
		if (tick) begin                             // see [R1] see [R3]
			next_rd_valid = buf_valid;
			if (buf_valid)
				next_rd_data = buf_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt       <= '0;
			rd_clk        <= 1'b0;
			rd_data_clk_p <= 1'b0;
			rd_data_clk_n <= 1'b1;
			rd_data       <= '0;
			rd_valid      <= 1'b0;
		end else begin
			div_cnt       <= next_div_cnt;
			rd_clk        <= next_rd_clk;
			rd_data_clk_p <= next_rd_clk;
			rd_data_clk_n <= ~next_rd_clk;
			rd_data       <= next_rd_data;
			rd_valid      <= next_rd_valid;
		end
	end

	// Helper logic for the checks below
	logic [ddrm_pkg::BEAT_W-1:0] push_cnt;
	logic [ddrm_pkg::DATA_W-1:0] wword;
	assign wword = mem[widx];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			push_cnt <= '0;
		else if (rd_start)
			push_cnt <= '0;
		else if (push)
			push_cnt <= ddrm_pkg::BEAT_W'(push_cnt + 1'b1);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_half_quiet;
		!$changed(rd_data_clk_p) [*3];
	endsequence

	property p_rd_clk_free;
		$changed(rd_data_clk_p) |=> s_half_quiet ##1 $changed(rd_data_clk_p);
	endproperty
	a_rd_clk_free: assert property (p_rd_clk_free) else $error("read clock stalled"); // see [R3]

	property p_rd_aligned;
		$changed(rd_data) |-> $changed(rd_data_clk_p) && rd_valid;
	endproperty
	a_rd_aligned: assert property (p_rd_aligned) else $error("read word off clock edge"); // see [R1]

	property p_rd_len;
		$fell(rd_act) |-> push_cnt == rd_bl;
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("read burst length wrong"); // see [R6]

	property p_mrs_bl4;
		(cmd == ddrm_pkg::CMD_MRS && sync2.addr[ddrm_pkg::MR_BL_LSB +: 2] == ddrm_pkg::MR_BL_4) |=>
			burst_len == ddrm_pkg::BL_4;
	endproperty
	a_mrs_bl4: assert property (p_mrs_bl4) else $error("burst length not set"); // see [R6]

	property p_mode_on_rise;
		$changed(burst_len) |-> $past(cclk_rise) && !$past(sync2.cs_n);
	endproperty
	a_mode_on_rise: assert property (p_mode_on_rise) else $error("mode changed off clock"); // see [R4]

	property p_cs_ignore;
		(cclk_rise && sync2.cs_n) |=> $stable(burst_len) && !$rose(rd_act) && !$rose(ref_done);
	endproperty
	a_cs_ignore: assert property (p_cs_ignore) else $error("command taken while deselected"); // see [R9]

	property p_bank_sel;
		rd_start |=> rd_bank == $past(sync2.bank);
	endproperty
	a_bank_sel: assert property (p_bank_sel) else $error("read bank not from pins"); // see [R7]

	property p_refresh;
		(cmd == ddrm_pkg::CMD_AREF && bank_free) |=> ref_done && busy[$past(sync2.bank)] != '0;
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh not started"); // see [R8]

	property p_wr_beat;
		(wr_act && dclk_edge && wr_beat != ddrm_pkg::BEAT_W'(wr_bl - 1'b1)) |=>
			wr_act && wr_beat == ddrm_pkg::BEAT_W'($past(wr_beat) + 1'b1);
	endproperty
	a_wr_beat: assert property (p_wr_beat) else $error("write beat not counted"); // see [R5]

	property p_wr_mask;
		(wr_act && dclk_edge && sync2.wr_mask) |=> mem[$past(widx)] == $past(wword);
	endproperty
	a_wr_mask: assert property (p_wr_mask) else $error("masked word written"); // see [R10]

	property p_no_turn;
		(!rd_act && !buf_valid) |=> $stable(rd_data);
	endproperty
	a_no_turn: assert property (p_no_turn) else $error("read pins moved without read"); // see [R2]
endmodule
`default_nettype wire

// ==== bench/ddrm_ctrl_model.sv ====
// Memory controller model that drives the command and write pins of the port.
// Assumes the bench calls its tasks one at a time; times are on the link's own base.
`timescale 1ns/1ns
`default_nettype none
module ddrm_ctrl_model (
	// Command pins
	output var logic        cmd_clk_p,
	output var logic        cmd_clk_n,
	output var logic        cs_n,
	output var logic        we_n,
	output var logic        ref_n,
	output var logic [2:0]  bank_addr,
	output var logic [5:0]  addr,
	// Write pins
	output var logic        wr_data_clk_p,
	output var logic        wr_data_clk_n,
	output var logic [17:0] wr_data,
	output var logic        wr_mask
);
	// Idle and deselected; both link clocks stand still between frames
	initial begin
		cmd_clk_p = 1'b0;
		cmd_clk_n = 1'b1;
		cs_n = 1'b1;
		we_n = 1'b1;
		ref_n = 1'b1;
		bank_addr = 3'h0;
		addr = 6'h00;
		wr_data_clk_p = 1'b0;
		wr_data_clk_n = 1'b1;
		wr_data = 18'h0_0000;
		wr_mask = 1'b0;
	end

	// One command per rising command clock, held over the whole high phase
	task automatic cmd(input logic cs, input logic we, input logic rf,
		input logic [2:0] b, input logic [5:0] a);
		cs_n = cs;
		we_n = we;
		ref_n = rf;
		bank_addr = b;
		addr = a;
		#31 cmd_clk_p = 1'b1;
		cmd_clk_n = 1'b0;
		#62 cmd_clk_p = 1'b0;
		cmd_clk_n = 1'b1;
		// Released lines deselect or show the inverse, not a stale copy
		#32 cs_n = 1'b1;
		we_n = ~we;
		ref_n = ~rf;
		bank_addr = ~b;
		addr = ~a;
	endtask

	// Burst on back-to-back data clock edges, one word per edge
	task automatic wr_burst(input logic [17:0] d [8], input logic [7:0] m, input int n);
		for (int i = 0; i < n; i++) begin
			wr_data = d[i];
			wr_mask = m[i];
			#31 wr_data_clk_p = ~wr_data_clk_p;
			wr_data_clk_n = ~wr_data_clk_p;
			#31;
		end
		wr_data = ~wr_data;
		wr_mask = ~wr_mask;
	endtask
endmodule
`default_nettype wire

// ==== bench/ddrm_port_tb_top.sv ====
// Self-checking bench for the separate-I/O DDR memory port.
// Assumes the controller model drives every link pin; bench owns clk and rst_n.
`timescale 1ns/1ns
`default_nettype none
module ddrm_port_tb_top;
	logic        clk, rst_n, cmd_clk_p, cmd_clk_n, cs_n, we_n, ref_n;
	logic [2:0]  bank_addr;
	logic [5:0]  addr;
	logic        wr_data_clk_p, wr_data_clk_n, wr_mask;
	logic        rd_data_clk_p, rd_data_clk_n, rd_valid, ref_done;
	logic [17:0] wr_data, rd_data;
	logic [3:0]  burst_len, refresh_row;
	int          errors, checks_done;
	logic [17:0] mem [8][64];

	ddrm_ctrl_model ctl (.cmd_clk_p, .cmd_clk_n, .cs_n, .we_n, .ref_n, .bank_addr, .addr,
		.wr_data_clk_p, .wr_data_clk_n, .wr_data, .wr_mask);
	ddrm_port #(.BUF_DEPTH(2)) uut (.clk, .rst_n, .cmd_clk_p, .cmd_clk_n, .cs_n, .we_n,
		.ref_n, .bank_addr, .addr, .wr_data_clk_p, .wr_data_clk_n, .wr_data, .wr_mask,
		.rd_data_clk_p, .rd_data_clk_n, .rd_data, .rd_valid, .burst_len, .ref_done,
		.refresh_row);

	// 100 MHz system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		// Unknown read data must never pass as a match
		if (got !== exp || $isunknown(got)) begin
			errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Reset held two cycles; outputs checked in and out of it
	task automatic t_reset();
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({rd_data_clk_p, rd_data_clk_n, rd_valid, ref_done}, 4'h4);
		rst_n = 1'b1;
		chk(burst_len, ddrm_pkg::BL_RST);
		chk(refresh_row, 4'h0);
		repeat (4) @(posedge clk);
		#1;
		$display("Test reset done");
	endtask

	// Mode set; one edge passes so the next command never shares a time step
	task automatic ms(input logic cs, input logic [1:0] code, input logic [3:0] e);
		ctl.cmd(cs, 1'b0, 1'b0, 3'h0, {4'h0, code});
		@(posedge clk);
		#1 chk(burst_len, e);
	endtask

	// Model updated only for selected, unmasked words
	task automatic wr(input logic cs, input logic [2:0] b, input logic [5:0] c0,
		input int n, input logic [17:0] base, input logic [7:0] m);
		logic [17:0] d [8];
		for (int i = 0; i < 8; i++) begin
			d[i] = base + 18'(i);
			if (i < n && !m[i] && !cs) mem[b][6'(c0 + i)] = d[i];
		end
		ctl.cmd(cs, 1'b0, 1'b1, b, c0);
		ctl.wr_burst(d, m, n);
		repeat (4) @(posedge clk);
		#1;
	endtask

	// Read while watching every read clock toggle
	task automatic rd(input logic [2:0] b, input logic [5:0] c0, input int n);
		int k, c, lt;
		logic lp;
		logic [17:0] pd;
		fork
			ctl.cmd(1'b0, 1'b1, 1'b1, b, c0);
			begin
				lp = rd_data_clk_p;
				pd = rd_data;
				k = 0;
				c = 0;
				lt = -1;
				while (k <= n && c < 400) begin
					@(posedge clk);
					#1 c++;
					if (rd_data_clk_p === lp) chk(rd_data, pd);
					else begin
						chk(rd_data_clk_n ^ rd_data_clk_p, 1'b1);
						if (lt >= 0) chk(c - lt, ddrm_pkg::RD_HALF_CYC);
						lt = c;
						lp = rd_data_clk_p;
						if (k == n) begin
							chk(rd_valid, 1'b0);
							k++;
						end else if (k > 0 || rd_valid === 1'b1) begin
							chk({rd_valid, rd_data}, {1'b1, mem[b][6'(c0 + k)]});
							k++;
						end
					end
					pd = rd_data;
				end
				if (k <= n) begin
					chk(k, n + 1);
					close_out();
				end
			end
		join
	endtask

	// Refresh with a watch for the one-cycle pulse
	task automatic rf(input logic cs, input logic [2:0] b, input logic [3:0] row);
		logic seen;
		seen = 1'b0;
		fork
			ctl.cmd(cs, 1'b1, 1'b0, b, 6'h00);
			for (int c = 0; c < 16; c++) begin
				@(posedge clk);
				#1;
				if (ref_done === 1'b1 && !seen) begin
					seen = 1'b1;
					chk(refresh_row, row);
					@(posedge clk);
					#1 chk(ref_done, 1'b0);
				end
			end
		join
		chk(seen, !cs);
	endtask

	task automatic t_mode();
		ms(1'b0, ddrm_pkg::MR_BL_4, ddrm_pkg::BL_4);
		ms(1'b0, ddrm_pkg::MR_BL_8, ddrm_pkg::BL_8);
		ms(1'b0, 2'h3, ddrm_pkg::BL_8);
		ms(1'b1, ddrm_pkg::MR_BL_4, ddrm_pkg::BL_8);
		ms(1'b0, ddrm_pkg::MR_BL_2, ddrm_pkg::BL_2);
		$display("Test mode done");
	endtask

	// Same column in every bank, distinct data
	task automatic t_banks();
		for (int b = 0; b < 8; b++) wr(1'b0, 3'(b), 6'h05, 2, 18'h1_0000 + 18'(b * 256), 8'h00);
		for (int b = 0; b < 8; b++) rd(3'(b), 6'h05, 2);
		$display("Test banks done");
	endtask

	// Masked words on both edges, burst across the column end
	task automatic t_mask_wrap();
		ms(1'b0, ddrm_pkg::MR_BL_4, ddrm_pkg::BL_4);
		wr(1'b0, 3'h2, 6'h3e, 4, 18'h3_0000, 8'h00);
		wr(1'b0, 3'h2, 6'h3e, 4, 18'h3_1000, 8'h06);
		rd(3'h2, 6'h3e, 4);
		ms(1'b0, ddrm_pkg::MR_BL_2, ddrm_pkg::BL_2);
		rd(3'h2, 6'h00, 2);
		$display("Test mask_wrap done");
	endtask

	// Longest burst, then a deselected write that must not land
	task automatic t_bl8_cs();
		ms(1'b0, ddrm_pkg::MR_BL_8, ddrm_pkg::BL_8);
		// Known contents first, so the masked end words have something to keep
		wr(1'b0, 3'h4, 6'h08, 8, 18'h2_0000, 8'h00);
		wr(1'b0, 3'h4, 6'h08, 8, 18'h2_2200, 8'h81);
		rd(3'h4, 6'h08, 8);
		wr(1'b1, 3'h4, 6'h08, 8, 18'h3_3300, 8'h00);
		rd(3'h4, 6'h08, 8);
		$display("Test bl8_cs done");
	endtask

	// Per-bank row counters; data survives refresh
	task automatic t_refresh();
		rf(1'b0, 3'h3, 4'h0);
		rf(1'b0, 3'h3, 4'h1);
		rf(1'b0, 3'h5, 4'h0);
		rf(1'b1, 3'h5, 4'h0);
		rf(1'b0, 3'h5, 4'h1);
		ms(1'b0, ddrm_pkg::MR_BL_2, ddrm_pkg::BL_2);
		rd(3'h3, 6'h05, 2);
		$display("Test refresh done");
	endtask

	// Main sequence, with a second reset at the end
	initial begin
		errors = 0;
		checks_done = 0;
		rst_n = 1'b0;
		t_reset();
		t_mode();
		t_banks();
		t_mask_wrap();
		t_bl8_cs();
		t_refresh();
		ms(1'b0, ddrm_pkg::MR_BL_4, ddrm_pkg::BL_4);
		t_reset();
		close_out();
	end
endmodule
`default_nettype wire
